// ===== rtl/ldsc_map.vh
// constants and register map of the laser drive safety control block
//
// Functional notes
// - no fault and no self-test window: supply gate output held low, laser supply connected.
// - drive pin shorted to ground or supply: supply gate output goes high.
// - ground path at drive pin trips detector, cuts current, raises gate.
// - detector tests itself by pulling drive pin low with supply gated off.
// - self-test failing because pin stays high counts as a laser fault.
// - any calibration field bit (3:1) set selects continuous drive while the code pair and the range fields (7:6) of the control pair match.
`ifndef LDSC_MAP_VH
`define LDSC_MAP_VH

// ==========================================================
// register offsets
`define LDSC_ADDR_CTRL_PRIMARY 7'h1a
`define LDSC_ADDR_CODE         7'h1c
`define LDSC_ADDR_CODE_INV     7'h1d
`define LDSC_ADDR_CTRL_MIRROR  7'h1f

// ==========================================================
// field positions
`define LDSC_RANGE_HI   7
`define LDSC_RANGE_LO   6
`define LDSC_CAL_HI     3
`define LDSC_CAL_LO     1
`define LDSC_RANGE_LOW  2'h1

// ==========================================================
// reset values
`define LDSC_RST_CTRL_PRIMARY 8'h40
`define LDSC_RST_CTRL_MIRROR  8'h80
`define LDSC_RST_CODE         8'h00
`define LDSC_RST_CODE_INV     8'hff

// ==========================================================
// self-test timing
`define LDSC_TEST_PERIOD_US  16'd100
`define LDSC_TEST_PULL_NS    16'd800
`define LDSC_CLK_NS          16'd8
// counts in clock cycles, period_us * 1000 / clk_ns and pull_ns / clk_ns;
// written out because the 16-bit product 100 * 1000 would wrap
`define LDSC_TEST_PERIOD_CYC 16'd12500
`define LDSC_TEST_PULL_CYC   16'd100

`endif

// ===== rtl/ldsc_self_test.v
// periodic self-test sequencer of the drive pin fault detector
`timescale 1ns/1ps
`include "ldsc_map.vh"
module ldsc_self_test (
  // clock and reset
  input  wire       clk,
  input  wire       reset,
  // pin observation
  input  wire       pin_low,
  // results
  output reg        test_active,
  output reg        test_fail
);
  localparam S_WAIT = 2'b01;
  localparam S_PULL = 2'b10;

  reg [1:0]  state;
  reg [15:0] count;

  // ==========================================================
  // wait, then gate supply and pull pin low; pin must follow at window end
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      state       <= S_WAIT;
      count       <= 16'h0000;
      test_active <= 1'b0;
      test_fail   <= 1'b0;
    end else begin
      test_fail <= 1'b0;
      case (state)
        S_WAIT: begin
          if (count >= `LDSC_TEST_PERIOD_CYC - 16'd1) begin
            count       <= 16'h0000;
            state       <= S_PULL;
            test_active <= 1'b1;
          end else begin
            count <= count + 16'd1;
          end
        end
        S_PULL: begin
          if (count >= `LDSC_TEST_PULL_CYC - 16'd1) begin
            count       <= 16'h0000;
            state       <= S_WAIT;
            test_active <= 1'b0;
            test_fail   <= ~pin_low;
          end else begin
            count <= count + 16'd1;
          end
        end
        default: begin
          state       <= S_WAIT;
          count       <= 16'h0000;
          test_active <= 1'b0;
        end
      endcase
    end
  end
endmodule

// ===== rtl/ldsc_top.v
// laser drive safety control: register file, drive control and fault latch
`timescale 1ns/1ps
`include "ldsc_map.vh"
module ldsc_top (
  // clock and reset
  input  wire       clk,
  input  wire       reset,
  // register write/read port from the serial block
  input  wire       reg_write,
  input  wire [6:0] reg_addr,
  input  wire [7:0] reg_wdata,
  output reg  [7:0] reg_rdata,
  // analog comparator results at the drive pin
  input  wire       pin_short_gnd,
  input  wire       pin_short_supply,
  input  wire       pin_low,
  // laser drive
  input  wire       frame_pulse,
  output reg        laser_supply_gate_n,
  output reg        drive_current_on,
  output reg        drive_pull_low,
  output reg  [7:0] drive_current,
  output reg  [1:0] drive_range,
  output reg        config_valid,
  output reg        laser_fault
);
  reg  [7:0] laser_control_primary;
  reg  [7:0] drive_current_code;
  reg  [7:0] drive_current_code_inverse;
  reg  [7:0] laser_control_mirror;
  wire       test_active;
  wire       test_fail;
  wire       cal_mode;
  wire       pair_ok;
  wire       fault_now;

  // decode of a register address, used by write and read paths
  function hit;
    input [6:0] a;
    input [6:0] b;
    begin
      hit = (a == b);
    end
  endfunction

  ldsc_self_test u_test (
    .clk         (clk),
    .reset       (reset),
    .pin_low     (pin_low),
    .test_active (test_active),
    .test_fail   (test_fail)
  );

  // ==========================================================
  // registers written by the host; the host restores them after reset
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      laser_control_primary      <= `LDSC_RST_CTRL_PRIMARY;
      drive_current_code         <= `LDSC_RST_CODE;
      drive_current_code_inverse <= `LDSC_RST_CODE_INV;
      laser_control_mirror       <= `LDSC_RST_CTRL_MIRROR;
    end else if (reg_write) begin
      if (hit(reg_addr, `LDSC_ADDR_CTRL_PRIMARY))
        laser_control_primary <= reg_wdata;
      if (hit(reg_addr, `LDSC_ADDR_CODE))
        drive_current_code <= reg_wdata;
      if (hit(reg_addr, `LDSC_ADDR_CODE_INV))
        drive_current_code_inverse <= reg_wdata;
      if (hit(reg_addr, `LDSC_ADDR_CTRL_MIRROR))
        laser_control_mirror <= reg_wdata;
    end
  end

  // read data registered; unmapped addresses read zero
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= hit(reg_addr, `LDSC_ADDR_CTRL_PRIMARY) ? laser_control_primary :
                   hit(reg_addr, `LDSC_ADDR_CODE)         ? drive_current_code :
                   hit(reg_addr, `LDSC_ADDR_CODE_INV)     ? drive_current_code_inverse :
                   hit(reg_addr, `LDSC_ADDR_CTRL_MIRROR)  ? laser_control_mirror :
                   8'h00;
    end
  end

  // ==========================================================
  // drive control
  // any non-zero calibration field selects continuous drive
  assign cal_mode = |laser_control_primary[`LDSC_CAL_HI:`LDSC_CAL_LO];
  // a mismatched complement pair keeps the current off: safer than guessing
  assign pair_ok = (drive_current_code == ~drive_current_code_inverse) &&
                   (laser_control_primary[`LDSC_RANGE_HI:`LDSC_RANGE_LO] ==
                    ~laser_control_mirror[`LDSC_RANGE_HI:`LDSC_RANGE_LO]);
  assign fault_now = pin_short_gnd | pin_short_supply | test_fail;

  // fault latch: only reset releases it
  always @(posedge clk or posedge reset) begin
    if (reset)
      laser_fault <= 1'b0;
    else if (fault_now)
      laser_fault <= 1'b1;
  end

  // outputs, each from a flip-flop
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      laser_supply_gate_n <= 1'b1;
      drive_current_on    <= 1'b0;
      drive_pull_low      <= 1'b0;
      drive_current       <= 8'h00;
      drive_range         <= `LDSC_RANGE_LOW;
      config_valid        <= 1'b0;
    end else begin
      config_valid  <= pair_ok;
      drive_current <= drive_current_code;
      drive_range   <= laser_control_primary[`LDSC_RANGE_HI:`LDSC_RANGE_LO];
      if (laser_fault | fault_now) begin
        laser_supply_gate_n <= 1'b1;
        drive_current_on    <= 1'b0;
        drive_pull_low      <= 1'b0;
      end else if (test_active) begin
        laser_supply_gate_n <= 1'b1;
        drive_current_on    <= 1'b0;
        drive_pull_low      <= 1'b1;
      end else begin
        laser_supply_gate_n <= 1'b0;
        drive_current_on    <= pair_ok & (cal_mode | frame_pulse);
        drive_pull_low      <= 1'b0;
      end
    end
  end
endmodule

// ===== test/ldsc_properties.sv
// checker of the laser safety outputs of ldsc_top
`timescale 1ns/1ps
`include "ldsc_map.vh"
module ldsc_properties (
  // clock and reset
  input wire clk,
  input wire reset,
  // fault inputs
  input wire pin_short_gnd,
  input wire pin_short_supply,
  // watched outputs
  input wire laser_supply_gate_n,
  input wire drive_current_on,
  input wire drive_pull_low,
  input wire config_valid,
  input wire laser_fault
);
  // ====
  // one domain, so clock and disable are given once
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  a_fault_shut: assert property (
    laser_fault |-> laser_supply_gate_n && !drive_current_on) else $error("fault not shut");
  a_gnd_trip: assert property (
    pin_short_gnd |=> laser_fault && laser_supply_gate_n) else $error("ground short missed");
  a_supply_trip: assert property (
    pin_short_supply |=> laser_fault) else $error("supply short missed");
  a_fault_latch: assert property (
    laser_fault |=> laser_fault) else $error("fault cleared without reset");
  a_test_gate: assert property (
    drive_pull_low |-> laser_supply_gate_n && !drive_current_on) else $error("test with supply on");
  a_pull_width: assert property (
    $rose(drive_pull_low) |-> drive_pull_low [*8]) else $error("test pull too short");
  a_normal_gate: assert property (
    $fell(drive_pull_low) |-> ##[0:2] (!laser_supply_gate_n || laser_fault))
    else $error("supply not restored");
  a_pair_off: assert property (
    !config_valid |-> !drive_current_on) else $error("bad pair drives");
  // helper count of pull cycles; a fault may end the window early
  reg [15:0] pull_len;
  always @(posedge clk or posedge reset) begin
    if (reset)
      pull_len <= 16'h0000;
    else if (drive_pull_low)
      pull_len <= pull_len + 16'h0001;
    else
      pull_len <= 16'h0000;
  end
  a_pull_span: assert property (
    $fell(drive_pull_low) && !laser_fault |-> pull_len == `LDSC_TEST_PULL_CYC)
    else $error("test pull width wrong");
  // main scenarios
  cover property ($rose(laser_fault));
  cover property ($rose(drive_pull_low));
  cover property ($fell(config_valid));
endmodule
bind ldsc_top ldsc_properties chk_u (.*);

// ===== test/ldsc_pin_model.sv
// drive pin model: reaches ground under the test pull unless held high
`timescale 1ns/1ps
module ldsc_pin_model (
  // control
  input  wire drive_pull_low,
  input  wire stuck_high,
  // comparator view
  output wire pin_low
);
  // a pin shorted high never falls, so the self-test must see it
  assign pin_low = drive_pull_low & ~stuck_high;
endmodule

// ===== test/tb_ldsc_top.sv
// testbench of ldsc_top: register programming, self-test and faults
`timescale 1ns/1ps
module tb_ldsc_top;
  // ====
  // bench signals
  reg        clk = 1'h0, reset = 1'h1, reg_write = 1'h0, stuck = 1'h0;
  reg        pin_short_gnd = 1'h0, pin_short_supply = 1'h0, frame_pulse = 1'h0;
  reg  [6:0] reg_addr = 7'h00;
  reg  [7:0] reg_wdata = 8'h00, code;
  reg  [7:0] nv [0:3];
  wire [7:0] reg_rdata, drive_current;
  wire [1:0] drive_range;
  wire       pin_low, gate_n, cur_on, pull, cfg_ok, fault;
  integer    error_cnt = 0, checks = 0, i, k;
  always #4 clk = ~clk;
  ldsc_top dut_u (.clk(clk), .reset(reset), .reg_write(reg_write), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .pin_short_gnd(pin_short_gnd),
    .pin_short_supply(pin_short_supply), .pin_low(pin_low), .frame_pulse(frame_pulse),
    .laser_supply_gate_n(gate_n), .drive_current_on(cur_on), .drive_pull_low(pull),
    .drive_current(drive_current), .drive_range(drive_range), .config_valid(cfg_ok),
    .laser_fault(fault));
  ldsc_pin_model pin_u (.drive_pull_low(pull), .stuck_high(stuck), .pin_low(pin_low));
  // ====
  // compare, port cycles, reset and bounded waits
  task chk(input string n, input [7:0] e, input [7:0] s);
    begin
      checks = checks + 1;
      if (s !== e) begin
        error_cnt = error_cnt + 1;
        $display("ERROR %0s expected %h seen %h", n, e, s);
      end
    end
  endtask
  task wr(input [6:0] a, input [7:0] d);
    begin
      @(negedge clk);
      reg_write = 1'h1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge clk);
      reg_write = 1'h0;
    end
  endtask
  // read data lags the address by one cycle
  task rd(input [6:0] a, input [7:0] e);
    begin
      @(negedge clk);
      reg_addr = a;
      repeat (2) @(negedge clk);
      chk("reg_rdata", e, reg_rdata);
    end
  endtask
  task do_reset;
    begin
      reset = 1'h1;
      repeat (5) @(negedge clk);
      reset = 1'h0;
      repeat (3) @(negedge clk);
    end
  endtask
  // the self-test period is 12500 cycles, so 13000 bounds one window
  task wait_pull(input v);
    begin
      for (i = 0; i < 13000 && pull !== v; i = i + 1) @(negedge clk);
      chk("drive_pull_low", v, pull);
      if (pull !== v) end_sim;
      repeat (3) @(negedge clk);
    end
  endtask
  task end_sim;
    begin
      $display("checks %0d error_cnt %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
    end
  endtask
  // ====
  // main sequence
  initial begin
    do_reset;
    rd(7'h1a, 8'h40);
    rd(7'h1c, 8'h00);
    rd(7'h1d, 8'hff);
    rd(7'h1f, 8'h80);
    rd(7'h20, 8'h00);
    chk("gate_n", 8'h00, gate_n);
    // calibration field on: current flows without frame pulses
    wr(7'h1a, 8'h4e);
    code = 8'h00;
    for (k = 0; k < 3; k = k + 1) begin
      code = code + 8'h10;
      wr(7'h1c, code);
      wr(7'h1d, ~code);
      repeat (3) @(negedge clk);
      chk("drive_current", code, drive_current);
      chk("cur_on", 8'h01, cur_on);
    end
    // pulsed mode follows the frame pulse
    wr(7'h1a, 8'h40);
    repeat (3) @(negedge clk);
    chk("cur_on", 8'h00, cur_on);
    frame_pulse = 1'h1;
    repeat (2) @(negedge clk);
    chk("cur_on", 8'h01, cur_on);
    // target missed: minimum code, then the high range
    wr(7'h1c, 8'h00);
    wr(7'h1d, 8'hff);
    wr(7'h1a, 8'h8e);
    wr(7'h1f, 8'h40);
    repeat (3) @(negedge clk);
    chk("drive_range", 8'h02, drive_range);
    chk("config_valid", 8'h01, cfg_ok);
    rd(7'h1f, 8'h40);
    nv[3] = reg_rdata;
    // target met in the high range; the host keeps the full set
    wr(7'h1c, 8'h20);
    wr(7'h1d, 8'hdf);
    rd(7'h1a, 8'h8e);
    nv[0] = reg_rdata;
    rd(7'h1c, 8'h20);
    nv[1] = reg_rdata;
    rd(7'h1d, 8'hdf);
    nv[2] = reg_rdata;
    // code written without its inverse must stop the drive
    wr(7'h1c, 8'h30);
    repeat (3) @(negedge clk);
    chk("config_valid", 8'h00, cfg_ok);
    chk("cur_on", 8'h00, cur_on);
    // healthy self-test, then one with the pin held high
    for (k = 0; k < 2; k = k + 1) begin
      do_reset;
      stuck = k[0];
      wait_pull(1'h1);
      chk("gate_n", 8'h01, gate_n);
      wait_pull(1'h0);
      chk("fault", k[7:0], fault);
      chk("gate_n", k[7:0], gate_n);
    end
    stuck = 1'h0;
    // short pulses to ground and supply stay latched
    for (k = 0; k < 2; k = k + 1) begin
      do_reset;
      pin_short_gnd = ~k[0];
      pin_short_supply = k[0];
      @(negedge clk);
      pin_short_gnd = 1'h0;
      pin_short_supply = 1'h0;
      repeat (20) @(negedge clk);
      chk("fault", 8'h01, fault);
      chk("gate_n", 8'h01, gate_n);
      chk("cur_on", 8'h00, cur_on);
    end
    do_reset;
    chk("fault", 8'h00, fault);
    // reset drops the calibration until the host writes the saved set back
    frame_pulse = 1'h0;
    repeat (2) @(negedge clk);
    chk("cur_on", 8'h00, cur_on);
    chk("drive_range", 8'h01, drive_range);
    wr(7'h1a, nv[0]);
    wr(7'h1c, nv[1]);
    wr(7'h1d, nv[2]);
    wr(7'h1f, nv[3]);
    repeat (3) @(negedge clk);
    chk("drive_current", 8'h20, drive_current);
    chk("drive_range", 8'h02, drive_range);
    chk("cur_on", 8'h01, cur_on);
    end_sim;
  end
endmodule
